// *** core/tms_pkg.sv ***
// Constants, field layout and bus carrier for the timer mode/status block.
// Assumes a Wishbone classic master with a byte address and 32-bit data.
package tms_pkg;
   localparam int TMS_NCH = 3;
   localparam int TMS_CW = 16;
   // Register byte addresses
   localparam logic [7:0] TMS_ADR_MODE = 8'h00;
   localparam logic [7:0] TMS_ADR_STA = 8'h04;
   localparam logic [7:0] TMS_ADR_STC = 8'h08;
   localparam logic [7:0] TMS_ADR_CTRL = 8'h0c;
   // Channel pages 1..3 hold counter, match A, match B
   localparam logic [3:0] TMS_PAGE_FIRST = 4'h1;
   localparam logic [3:0] TMS_PAGE_LAST = 4'h3;
   localparam logic [3:0] TMS_OFS_CNT = 4'h0;
   localparam logic [3:0] TMS_OFS_A = 4'h4;
   localparam logic [3:0] TMS_OFS_B = 4'h8;
   // Mode register
   localparam logic [7:0] TMS_MODE_RESET = 8'h98;
   localparam logic [7:0] TMS_MODE_ONES = 8'h98;
   localparam int TMS_MODE_PHASE = 6;
   localparam int TMS_MODE_OVERFLOW_FLAG_DIRECTION = 5;
   localparam int TMS_MODE_PULSE = 0;
   // Status A / status C
   localparam logic [7:0] TMS_STA_RESET = 8'h88;
   localparam logic [7:0] TMS_STA_ONES = 8'h88;
   localparam int TMS_STA_EN = 4;
   localparam int TMS_STA_FLAG = 0;
   localparam logic [7:0] TMS_STC_RESET = 8'h88;
   localparam logic [7:0] TMS_STC_ONES = 8'h88;
   localparam int TMS_STC_WRAP = 2;
   localparam int TMS_STC_WRAP_EN = 6;
   // Control register fields
   localparam int TMS_CTRL_RUN = 0;
   localparam int TMS_CTRL_CAPT = 4;
   localparam int TMS_CTRL_CLR = 8;
   localparam int TMS_CTRL_SRC = 12;
   localparam int TMS_CTRL_PRESC = 16;
   // Reset values, counter maximum and count step
   localparam logic [15:0] TMS_CNT_RESET = 16'h0000;
   localparam logic [15:0] TMS_MATCH_RESET = 16'hffff;
   localparam logic [15:0] TMS_CNT_MAX = 16'hffff;
   localparam logic [15:0] TMS_CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {
      TMS_SRC_INTERNAL,
      TMS_SRC_RISE,
      TMS_SRC_FALL,
      TMS_SRC_BOTH
   } tms_src_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tms_wb_req_t;
endpackage

// *** core/tms_timer_core.sv ***
// Mode select, match-A status and three 16-bit counters with PWM output.
// Assumes one 40 MHz clock; pins are asynchronous and synchronised here.
//
// Notes on behaviour
// R1 - Mode register becomes 0x98 on reset and on standby.
// R2 - Mode bits 7, 4, 3 ignore writes and read one.
// R3 - Mode bit 6 picks normal or two-phase counting for channel 2.
// R4 - Two-phase: channel 2 counts up/down on every edge of both encoder pins.
// R5 - Up for B rise A low, A rise B high, etc; mirrored is down.
// R6 - Two-phase ignores channel 2 edge select and prescaler select.
// R7 - Two-phase keeps clear source, compare/capture and interrupts of channel 2.
// R8 - Mode bit 5: 0 wrap flag on overflow or underflow, 1 overflow only.
// R9 - Mode bits 2..0 put channels 2..0 into pulse-width output mode.
// R10 - Pulse mode: wave pin high on A match, low on B match.
// R11 - Status A becomes 0x88 on reset and on standby.
// R12 - Status A bits 7 and 3 ignore writes and read one.
// R13 - Status A bits 6..4 enable A-match requests of channels 2..0.
// R14 - Status A bits 2..0 set when counter equals compare register A.
// R15 - Capture copies counter into register A and sets the A flag.
// R16 - A flag clears only on a zero write after reading it as one.
// R17 - Writing one to an A flag leaves it unchanged.
// R18 - Channel 2 wrap flag in status C bit 2, read-then-zero clear.
// R19 - A request is high while flag and enable are both one.
// R20 - Encoder pins synchronised first; one count per detected edge.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module tms_timer_core
   import tms_pkg::*;
(
   // Clock, reset, standby
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic standby,
   // Wishbone slave
   input wire tms_wb_req_t wb_req,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // Pins
   input wire logic encoder_in_a,
   input wire logic encoder_in_b,
   input wire logic [2:0] capture_in,
   output logic [2:0] wave_out,
   // Requests
   output logic [2:0] a_irq_request,
   output logic wrap_irq_request_ch2
);

   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] lanes);
      logic [15:0] r;
      r = old_v;
      if (lanes[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (lanes[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   logic init, take, wr, rd, wb_ack_q;
   logic hit_mode, hit_sta, hit_stc, hit_ctrl, hit_ch;
   logic [31:0] wb_dat_q, rdata;
   logic [1:0] ch_idx;
   logic [3:0] ch_ofs;
   logic [7:0] mode_q;
   logic [2:0] a_en_q, a_flag_q, a_arm_q, a_flag_d, a_irq_q;
   logic wrap_en_q, wrap_flag_q, wrap_arm_q, wrap_flag_d, wrap_irq_q;
   logic [2:0] run_q, capt_q, clr_q;
   tms_src_t src_q;
   logic [1:0] presc_sel_q;
   logic [2:0] presc_q, presc_mask;
   logic presc_tick;
   logic [1:0] enc_m1_q, enc_s_q, enc_p_q;
   logic [2:0] cap_m1_q, cap_s_q, cap_p_q;
   logic [15:0] cnt_q [TMS_NCH], ma_q [TMS_NCH], mb_q [TMS_NCH];
   logic [2:0] chg_q, wave_q, up, dn, cmp_a, cmp_b, cap_evt, set_a;
   logic phase_up, phase_dn, a_rise, a_fall, b_rise, b_fall, ext_edge, wrap_set;

   // Standby returns the status and mode state to its reset image
   assign init = ~resetn | standby;

   // Bus decode
   assign take = wb_req.cyc & wb_req.stb & ~wb_ack_q;
   assign wr = take & wb_req.we;
   assign rd = take & ~wb_req.we;
   assign ch_ofs = wb_req.adr[3:0];

   always_comb begin
      hit_mode = 1'b0;
      hit_sta = 1'b0;
      hit_stc = 1'b0;
      hit_ctrl = 1'b0;
      hit_ch = 1'b0;
      ch_idx = 2'h0;
      if (wb_req.adr == TMS_ADR_MODE) begin
         hit_mode = 1'b1;
      end else if (wb_req.adr == TMS_ADR_STA) begin
         hit_sta = 1'b1;
      end else if (wb_req.adr == TMS_ADR_STC) begin
         hit_stc = 1'b1;
      end else if (wb_req.adr == TMS_ADR_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (wb_req.adr[7:4] >= TMS_PAGE_FIRST && wb_req.adr[7:4] <= TMS_PAGE_LAST) begin
         if (ch_ofs == TMS_OFS_CNT || ch_ofs == TMS_OFS_A || ch_ofs == TMS_OFS_B) begin
            hit_ch = 1'b1;
            ch_idx = 2'(wb_req.adr[7:4] - TMS_PAGE_FIRST);
         end
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_mode) begin
         rdata[7:0] = mode_q | TMS_MODE_ONES; // R2
      end else if (hit_sta) begin
         rdata[7:0] = TMS_STA_ONES; // R12
         rdata[TMS_STA_EN +: 3] = a_en_q;
         rdata[TMS_STA_FLAG +: 3] = a_flag_q;
      end else if (hit_stc) begin
         rdata[7:0] = TMS_STC_ONES;
         rdata[TMS_STC_WRAP_EN] = wrap_en_q;
         rdata[TMS_STC_WRAP] = wrap_flag_q;
      end else if (hit_ctrl) begin
         rdata[TMS_CTRL_RUN +: 3] = run_q;
         rdata[TMS_CTRL_CAPT +: 3] = capt_q;
         rdata[TMS_CTRL_CLR +: 3] = clr_q;
         rdata[TMS_CTRL_SRC +: 2] = src_q;
         rdata[TMS_CTRL_PRESC +: 2] = presc_sel_q;
      end else if (hit_ch) begin
         if (ch_ofs == TMS_OFS_CNT) begin
            rdata[15:0] = cnt_q[ch_idx];
         end else if (ch_ofs == TMS_OFS_A) begin
            rdata[15:0] = ma_q[ch_idx];
         end else begin
            rdata[15:0] = mb_q[ch_idx];
         end
      end
   end

   // One-cycle ack; unmapped addresses ack with zero data
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0000_0000;
      end else begin
         wb_ack_q <= take;
         if (rd) begin
            wb_dat_q <= rdata;
         end
      end
   end

   // Mode register
   always_ff @(posedge clk_sys) begin
      if (init) begin
         mode_q <= TMS_MODE_RESET; // R1
      end else if (wr && hit_mode && wb_req.sel[0]) begin
         mode_q <= wb_req.dat[7:0] | TMS_MODE_ONES; // R2 R3 R8 R9
      end
   end

   // Flag next states; a hardware set beats a clear in the same cycle
   always_comb begin
      for (int i = 0; i < TMS_NCH; i++) begin
         a_flag_d[i] = a_flag_q[i];
         if (set_a[i]) begin
            a_flag_d[i] = 1'b1; // R14 R15
         end else if (wr && hit_sta && wb_req.sel[0] && a_arm_q[i]
                      && !wb_req.dat[TMS_STA_FLAG + i]) begin
            a_flag_d[i] = 1'b0; // R16 R17
         end
      end
      wrap_flag_d = wrap_flag_q;
      if (wrap_set) begin
         wrap_flag_d = 1'b1;
      end else if (wr && hit_stc && wb_req.sel[0] && wrap_arm_q
                   && !wb_req.dat[TMS_STC_WRAP]) begin
         wrap_flag_d = 1'b0; // R18
      end
   end

   // Status A
   always_ff @(posedge clk_sys) begin
      if (init) begin
         a_en_q <= TMS_STA_RESET[TMS_STA_EN +: 3]; // R11
         a_flag_q <= TMS_STA_RESET[TMS_STA_FLAG +: 3];
         a_arm_q <= 3'h0;
      end else begin
         a_flag_q <= a_flag_d;
         if (wr && hit_sta && wb_req.sel[0]) begin
            a_en_q <= wb_req.dat[TMS_STA_EN +: 3]; // R13
         end
         if (rd && hit_sta) begin
            a_arm_q <= a_flag_q; // R16
         end else if (wr && hit_sta) begin
            a_arm_q <= 3'h0;
         end
      end
   end

   // Status C, wrap part of channel 2 only
   always_ff @(posedge clk_sys) begin
      if (init) begin
         wrap_en_q <= TMS_STC_RESET[TMS_STC_WRAP_EN];
         wrap_flag_q <= TMS_STC_RESET[TMS_STC_WRAP];
         wrap_arm_q <= 1'b0;
      end else begin
         wrap_flag_q <= wrap_flag_d;
         if (wr && hit_stc && wb_req.sel[0]) begin
            wrap_en_q <= wb_req.dat[TMS_STC_WRAP_EN];
         end
         if (rd && hit_stc) begin
            wrap_arm_q <= wrap_flag_q; // R18
         end else if (wr && hit_stc) begin
            wrap_arm_q <= 1'b0;
         end
      end
   end

   // Requests follow flag and enable in the same cycle as they change
   always_ff @(posedge clk_sys) begin
      if (init) begin
         a_irq_q <= 3'h0;
         wrap_irq_q <= 1'b0;
      end else begin
         a_irq_q <= a_flag_d & ((wr && hit_sta && wb_req.sel[0])
                                ? wb_req.dat[TMS_STA_EN +: 3] : a_en_q); // R13 R19
         wrap_irq_q <= wrap_flag_d & ((wr && hit_stc && wb_req.sel[0])
                                      ? wb_req.dat[TMS_STC_WRAP_EN] : wrap_en_q); // R7
      end
   end

   // Control register
   always_ff @(posedge clk_sys) begin
      if (init) begin
         run_q <= 3'h0;
         capt_q <= 3'h0;
         clr_q <= 3'h0;
         src_q <= TMS_SRC_INTERNAL;
         presc_sel_q <= 2'h0;
      end else if (wr && hit_ctrl) begin
         if (wb_req.sel[0]) begin
            run_q <= wb_req.dat[TMS_CTRL_RUN +: 3];
            capt_q <= wb_req.dat[TMS_CTRL_CAPT +: 3];
         end
         if (wb_req.sel[1]) begin
            clr_q <= wb_req.dat[TMS_CTRL_CLR +: 3];
            src_q <= tms_src_t'(wb_req.dat[TMS_CTRL_SRC +: 2]);
         end
         if (wb_req.sel[2]) begin
            presc_sel_q <= wb_req.dat[TMS_CTRL_PRESC +: 2];
         end
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         enc_m1_q <= 2'h0;
         enc_s_q <= 2'h0;
         enc_p_q <= 2'h0;
         cap_m1_q <= 3'h0;
         cap_s_q <= 3'h0;
         cap_p_q <= 3'h0;
      end else begin
         enc_m1_q <= {encoder_in_b, encoder_in_a}; // R20
         enc_s_q <= enc_m1_q;
         enc_p_q <= enc_s_q;
         cap_m1_q <= capture_in;
         cap_s_q <= cap_m1_q;
         cap_p_q <= cap_s_q;
      end
   end

   // Prescaler for channel 2 internal counting: divide by 1, 2, 4, 8
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         presc_q <= 3'h0;
      end else begin
         presc_q <= presc_q + 3'h1;
      end
   end

   always_comb begin
      case (presc_sel_q)
         2'h0: presc_mask = 3'h0;
         2'h1: presc_mask = 3'h1;
         2'h2: presc_mask = 3'h3;
         default: presc_mask = 3'h7;
      endcase
   end

   assign presc_tick = (presc_q & presc_mask) == presc_mask;

   // Encoder edge decode
   assign a_rise = enc_s_q[0] & ~enc_p_q[0];
   assign a_fall = ~enc_s_q[0] & enc_p_q[0];
   assign b_rise = enc_s_q[1] & ~enc_p_q[1];
   assign b_fall = ~enc_s_q[1] & enc_p_q[1];
   assign phase_up = (b_rise & ~enc_s_q[0]) | (a_rise & enc_s_q[1])
                   | (b_fall & enc_s_q[0]) | (a_fall & ~enc_s_q[1]); // R4 R5
   assign phase_dn = (a_rise & ~enc_s_q[1]) | (b_rise & enc_s_q[0])
                   | (a_fall & enc_s_q[1]) | (b_fall & ~enc_s_q[0]); // R4 R5

   always_comb begin
      case (src_q)
         TMS_SRC_RISE: ext_edge = a_rise;
         TMS_SRC_FALL: ext_edge = a_fall;
         TMS_SRC_BOTH: ext_edge = a_rise | a_fall;
         default: ext_edge = presc_tick;
      endcase
   end

   // Count steps, compare and capture events per channel
   always_comb begin
      up = {1'b0, run_q[1:0]};
      dn = 3'h0;
      if (mode_q[TMS_MODE_PHASE]) begin
         up[2] = run_q[2] & phase_up; // R3 R6
         dn[2] = run_q[2] & phase_dn;
      end else begin
         up[2] = run_q[2] & ext_edge;
      end
      for (int i = 0; i < TMS_NCH; i++) begin
         cmp_a[i] = chg_q[i] & ~capt_q[i] & (cnt_q[i] == ma_q[i]); // R14 R7
         cmp_b[i] = chg_q[i] & (cnt_q[i] == mb_q[i]);
         cap_evt[i] = capt_q[i] & cap_s_q[i] & ~cap_p_q[i];
         set_a[i] = cmp_a[i] | cap_evt[i]; // R15
      end
   end

   assign wrap_set = (up[2] & (cnt_q[2] == TMS_CNT_MAX))
                   | (dn[2] & (cnt_q[2] == TMS_CNT_RESET) & ~mode_q[TMS_MODE_OVERFLOW_FLAG_DIRECTION]); // R8

   // Counters and match registers; bus writes beat counting
   always_ff @(posedge clk_sys) begin
      if (init) begin
         for (int i = 0; i < TMS_NCH; i++) begin
            cnt_q[i] <= TMS_CNT_RESET;
            ma_q[i] <= TMS_MATCH_RESET;
            mb_q[i] <= TMS_MATCH_RESET;
         end
         chg_q <= 3'h0;
      end else begin
         for (int i = 0; i < TMS_NCH; i++) begin
            chg_q[i] <= 1'b0;
            if (wr && hit_ch && ch_idx == 2'(i) && ch_ofs == TMS_OFS_CNT) begin
               cnt_q[i] <= merge16(cnt_q[i], wb_req.dat[15:0], wb_req.sel[1:0]);
            end else if (clr_q[i] && cmp_a[i]) begin
               cnt_q[i] <= TMS_CNT_RESET; // R7
               chg_q[i] <= 1'b1;
            end else if (up[i]) begin
               cnt_q[i] <= cnt_q[i] + TMS_CNT_ONE; // R20
               chg_q[i] <= 1'b1;
            end else if (dn[i]) begin
               cnt_q[i] <= cnt_q[i] - TMS_CNT_ONE;
               chg_q[i] <= 1'b1;
            end
            // Capture wins over a software write in the same cycle
            if (cap_evt[i]) begin
               ma_q[i] <= cnt_q[i]; // R15
            end else if (wr && hit_ch && ch_idx == 2'(i) && ch_ofs == TMS_OFS_A) begin
               ma_q[i] <= merge16(ma_q[i], wb_req.dat[15:0], wb_req.sel[1:0]);
            end
            if (wr && hit_ch && ch_idx == 2'(i) && ch_ofs == TMS_OFS_B) begin
               mb_q[i] <= merge16(mb_q[i], wb_req.dat[15:0], wb_req.sel[1:0]);
            end
         end
      end
   end

   // Pulse outputs; B match wins when both land together
   always_ff @(posedge clk_sys) begin
      if (init) begin
         wave_q <= 3'h0;
      end else begin
         for (int i = 0; i < TMS_NCH; i++) begin
            if (!mode_q[TMS_MODE_PULSE + i]) begin
               wave_q[i] <= 1'b0; // R9
            end else if (cmp_b[i]) begin
               wave_q[i] <= 1'b0; // R10
            end else if (chg_q[i] && cnt_q[i] == ma_q[i]) begin
               wave_q[i] <= 1'b1; // R10
            end
         end
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign wave_out = wave_q;
   assign a_irq_request = a_irq_q;
   assign wrap_irq_request_ch2 = wrap_irq_q;

endmodule

// *** testbench/tms_timer_core_monitor.sv ***
// Port-level checks on the timer mode and match status core.
// Assumes binding to tms_timer_core; sees only its ports.
`timescale 1ns/1ps
module tms_timer_core_monitor
   import tms_pkg::*;
(
   // Clock and control
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic standby,
   // Bus
   input wire tms_wb_req_t wb_req,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Pins and requests
   input wire logic [2:0] wave_out,
   input wire logic [2:0] a_irq_request,
   input wire logic wrap_irq_request_ch2
);
   logic take;
   logic rd_ack;
   logic [7:0] adr_q;
   logic we_q;
   assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign rd_ack = wb_ack_o && !we_q;
   // Remember the taken request so read data can be judged in the ack cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         adr_q <= 8'h00;
         we_q <= 1'b1;
      end else if (take) begin
         adr_q <= wb_req.adr;
         we_q <= wb_req.we;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_NEXT: assert property (take |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   AST_MODE_ONES: assert property (rd_ack && adr_q == TMS_ADR_MODE |->
      (wb_dat_o[7:0] & TMS_MODE_ONES) == TMS_MODE_ONES)
      else $error("mode reserved bits not read as one");
   AST_STA_ONES: assert property (rd_ack && adr_q == TMS_ADR_STA |->
      (wb_dat_o[7:0] & TMS_STA_ONES) == TMS_STA_ONES)
      else $error("status A reserved bits not read as one");
   AST_STC_ONES: assert property (rd_ack && adr_q == TMS_ADR_STC |->
      (wb_dat_o[7:0] & TMS_STC_ONES) == TMS_STC_ONES)
      else $error("status C reserved bits not read as one");
   AST_UNMAPPED: assert property (rd_ack && adr_q[7:4] > TMS_PAGE_LAST |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_A_MASK: assert property (take && wb_req.we && wb_req.sel[0] &&
      wb_req.adr == TMS_ADR_STA && wb_req.dat[6:4] == 3'h0 |=> a_irq_request == 3'h0)
      else $error("A request stands with enables cleared");
   AST_WRAP_MASK: assert property (take && wb_req.we && wb_req.sel[0] &&
      wb_req.adr == TMS_ADR_STC && !wb_req.dat[TMS_STC_WRAP_EN] |=> !wrap_irq_request_ch2)
      else $error("wrap request stands with enable cleared");
   AST_STANDBY_OUT: assert property (standby |=>
      wave_out == 3'h0 && a_irq_request == 3'h0 && !wrap_irq_request_ch2)
      else $error("outputs active during standby");

   cover property (rd_ack && adr_q == TMS_ADR_STA);
   cover property (a_irq_request != 3'h0);
   cover property (standby);
endmodule

bind tms_timer_core tms_timer_core_monitor tms_timer_core_monitor_inst (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .standby(standby),
   .wb_req(wb_req),
   .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o),
   .wave_out(wave_out),
   .a_irq_request(a_irq_request),
   .wrap_irq_request_ch2(wrap_irq_request_ch2)
);

// *** testbench/tms_pin_model.sv ***
// Encoder and capture pin source for the timer core.
// Assumes the core synchronises the pins; steps are spaced to let it.
`timescale 1ns/1ps
module tms_pin_model (
   // Clock
   input wire logic clk_sys,
   // Pins towards the core
   output logic encoder_in_a,
   output logic encoder_in_b,
   output logic [2:0] capture_in
);
   logic [1:0] ph;
   initial begin
      encoder_in_a = 1'b0;
      encoder_in_b = 1'b0;
      capture_in = 3'h0;
      ph = 2'h0;
   end
   // Up order AB 00,01,11,10; down walks it backwards
   task automatic step(input logic up);
      logic [1:0] gray;
      ph = up ? ph + 2'h1 : ph - 2'h1;
      gray = {ph[1], ph[1] ^ ph[0]};
      @(posedge clk_sys);
      encoder_in_a <= gray[1];
      encoder_in_b <= gray[0];
      // Slower than synchroniser plus edge detect
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic cap(input int ch);
      @(posedge clk_sys);
      capture_in[ch] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      capture_in[ch] <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule

// *** testbench/tb_timer_mode_and_match_status_a.sv ***
// Self-checking bench for the timer mode and match status core.
// Assumes the pin model drives encoder and capture pins.
`timescale 1ns/1ps
module tb_timer_mode_and_match_status_a import tms_pkg::*;;
   logic clk_sys = 1'b0;
   logic resetn;
   logic standby;
   tms_wb_req_t wb_req;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   logic encoder_in_a;
   logic encoder_in_b;
   logic [2:0] capture_in;
   logic [2:0] wave_out;
   logic [2:0] a_irq_request;
   logic wrap_irq_request_ch2;
   int n_fail = 0;
   int n_checks = 0;

   always #12.5 clk_sys = ~clk_sys;

   tms_timer_core tms_timer_core_inst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .standby(standby),
      .wb_req(wb_req),
      .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o),
      .encoder_in_a(encoder_in_a),
      .encoder_in_b(encoder_in_b),
      .capture_in(capture_in),
      .wave_out(wave_out),
      .a_irq_request(a_irq_request),
      .wrap_irq_request_ch2(wrap_irq_request_ch2)
   );
   tms_pin_model tms_pin_model_inst (
      .clk_sys(clk_sys),
      .encoder_in_a(encoder_in_a),
      .encoder_in_b(encoder_in_b),
      .capture_in(capture_in)
   );

   task automatic results();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] rd);
      @(posedge clk_sys);
      // Ack must have dropped again before a new request goes out
      chk({31'h0, wb_ack_o}, 32'h0);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb(1'b1, adr, dat, rd);
   endtask
   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0, rd);
      chk(rd, exp);
   endtask

   task automatic t_regs();
      rchk(TMS_ADR_MODE, 32'h98);
      rchk(TMS_ADR_STA, 32'h88);
      rchk(TMS_ADR_STC, 32'h88);
      wr(TMS_ADR_MODE, 32'h0);
      rchk(TMS_ADR_MODE, 32'h98);
      wr(TMS_ADR_MODE, 32'h67);
      rchk(TMS_ADR_MODE, 32'hff);
      wr(TMS_ADR_MODE, 32'h0);
      wr(TMS_ADR_STA, 32'h77);
      rchk(TMS_ADR_STA, 32'hf8);
      chk({29'h0, a_irq_request}, 32'h0);
      wr(TMS_ADR_STA, 32'h0);
      rchk(TMS_ADR_STA, 32'h88);
      rchk(8'hf0, 32'h0);
   endtask
   // Channel 0 compare A, flag clear protocol and masking
   task automatic t_match();
      wr(8'h14, 32'h10);
      wr(TMS_ADR_STA, 32'h10);
      wr(TMS_ADR_CTRL, 32'h1);
      repeat (30) @(posedge clk_sys);
      chk({29'h0, a_irq_request}, 32'h1);
      rchk(TMS_ADR_STA, 32'h99);
      wr(TMS_ADR_STA, 32'h11);
      wr(TMS_ADR_STA, 32'h10);
      chk({29'h0, a_irq_request}, 32'h1);
      wr(TMS_ADR_STA, 32'h01);
      chk({29'h0, a_irq_request}, 32'h0);
      rchk(TMS_ADR_STA, 32'h89);
      wr(TMS_ADR_STA, 32'h10);
      chk({29'h0, a_irq_request}, 32'h0);
      rchk(TMS_ADR_STA, 32'h98);
   endtask
   task automatic t_pwm();
      int n;
      wr(TMS_ADR_MODE, 32'h2);
      wr(8'h24, 32'h8);
      wr(8'h28, 32'h20);
      wr(TMS_ADR_CTRL, 32'h2);
      n = 0;
      while (wave_out[1] !== 1'b1 && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      n = 0;
      while (wave_out[1] === 1'b1 && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n), 32'd24);
      chk({29'h0, wave_out}, 32'h0);
   endtask
   // Source and prescaler set to values that would change the count
   task automatic t_phase();
      wr(TMS_ADR_MODE, 32'h40);
      wr(TMS_ADR_CTRL, 32'h31044);
      wr(8'h30, 32'h0);
      repeat (8) tms_pin_model_inst.step(1'b1);
      rchk(8'h30, 32'h8);
      repeat (3) tms_pin_model_inst.step(1'b0);
      rchk(8'h30, 32'h5);
      tms_pin_model_inst.cap(2);
      rchk(8'h34, 32'h5);
      // Channel 1 flag still stands from its compare match in the pulse test
      rchk(TMS_ADR_STA, 32'h9e);
      wr(TMS_ADR_STC, 32'h40);
      wr(8'h30, 32'h0);
      tms_pin_model_inst.step(1'b0);
      rchk(8'h30, 32'hffff);
      chk({31'h0, wrap_irq_request_ch2}, 32'h1);
      rchk(TMS_ADR_STC, 32'hcc);
      wr(TMS_ADR_STC, 32'h0);
      chk({31'h0, wrap_irq_request_ch2}, 32'h0);
      rchk(TMS_ADR_STC, 32'h88);
      wr(TMS_ADR_MODE, 32'h60);
      wr(8'h30, 32'h0);
      tms_pin_model_inst.step(1'b0);
      rchk(TMS_ADR_STC, 32'h88);
   endtask
   task automatic t_standby();
      wr(TMS_ADR_MODE, 32'h47);
      @(posedge clk_sys);
      standby <= 1'b1;
      repeat (2) @(posedge clk_sys);
      standby <= 1'b0;
      rchk(TMS_ADR_MODE, 32'h98);
      rchk(TMS_ADR_STA, 32'h88);
   endtask

   initial begin
      resetn = 1'b0;
      standby = 1'b0;
      wb_req = '0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_match();
      t_pwm();
      t_phase();
      t_standby();
      results();
   end
   // Whole run needs about three hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      results();
   end
endmodule
